// ==== design/recoverable_fault_config.v ====
// Two recoverable fault channels with their configuration registers and interrupt.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "fault_map.vh"

module recoverable_fault_config (
    input  wire        clk_in,
    input  wire        reset_n_in,
    // Register port.
    input  wire [7:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        write_in,
    input  wire        read_in,
    output reg  [31:0] rdata_out,
    // Timer context.
    input  wire        timer_enabled_in,
    input  wire        write_protect_in,
    input  wire        prescale_tick_in,
    input  wire        cycle_end_in,
    input  wire [1:0]  compare_output_level_in,
    // Event inputs, bit 0 for fault A and bit 1 for fault B.
    input  wire [1:0]  fault_event_input_in,
    // Fault results, bit 0 or the low field for fault A and bit 1 or the high field for fault B; irq_out serves both.
    output reg  [1:0]  fault_state_out,
    output reg  [1:0]  capture_request_out,
    output reg  [5:0]  capture_action_out,
    output reg  [3:0]  capture_channel_select_out,
    output reg  [1:0]  halt_hardware_out,
    output reg  [1:0]  halt_software_out,
    output reg  [1:0]  non_recoverable_out,
    output reg  [1:0]  restart_out,
    output wire        irq_out
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg rst_meta;
    reg rst_sync_n;

    // Asserts at once, releases two edges after the pin goes high.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg  [31:0] fault_a_config;
    reg  [31:0] fault_b_config;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_enable;
    wire        cfg_writable;
    wire [31:0] wdata_kept;
    wire [1:0]  fault_onset;
    wire [1:0]  next_irq_status;

    // Fault configuration writes are dropped while the timer runs or protection is on.
    assign cfg_writable = ~timer_enabled_in & ~write_protect_in;

    // Reserved positions never store a one.
    assign wdata_kept = wdata_in & `CFG_WRITE_MASK;

    // Holds the two fault configurations and the interrupt enable.
    always @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fault_a_config <= `CFG_RESET;
            fault_b_config <= `CFG_RESET;
            irq_enable     <= `IRQ_ZERO;
        end else if (write_in) begin
            if (addr_in == `OFF_FAULT_A_CONFIG && cfg_writable) begin
                fault_a_config <= wdata_kept;
            end
            if (addr_in == `OFF_FAULT_B_CONFIG && cfg_writable) begin
                fault_b_config <= wdata_kept;
            end
            if (addr_in == `OFF_IRQ_ENABLE) begin
                irq_enable <= wdata_in[`IRQ_W-1:0];
            end
        end
    end

    // A new onset wins over a clear written in the same cycle.
    assign next_irq_status = (write_in && addr_in == `OFF_IRQ_CLEAR)
                           ? ((irq_status & ~wdata_in[`IRQ_W-1:0]) | fault_onset)
                           : (irq_status | fault_onset);

    // Sticky onset flags, one per fault.
    always @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_status <= `IRQ_ZERO;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Level interrupt while any enabled flag stands.
    assign irq_out = |(irq_status & irq_enable);

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Read data appear the cycle after the strobe and read zero otherwise.
    always @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_out <= `WORD_ZERO;
        end else if (read_in) begin
            case (addr_in)
                `OFF_FAULT_A_CONFIG: rdata_out <= fault_a_config;
                `OFF_FAULT_B_CONFIG: rdata_out <= fault_b_config;
                `OFF_IRQ_STATUS:     rdata_out <= {30'h00000000, irq_status};
                `OFF_IRQ_ENABLE:     rdata_out <= {30'h00000000, irq_enable};
                default:             rdata_out <= `WORD_ZERO;
            endcase
        end else begin
            rdata_out <= `WORD_ZERO;
        end
    end

    // ------------------------------------------------------------------------
    // Fault channels
    // ------------------------------------------------------------------------
    wire [63:0] cfg_flat;
    reg  [1:0]  state;
    reg  [1:0]  state_at_period_end;

    // Both configurations side by side so the channel loop can slice them.
    assign cfg_flat = {fault_b_config, fault_a_config};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : chan
            wire [31:0] cfg;
            reg         evt_meta;
            reg         evt_sync;
            wire        evt_filtered;
            wire        blanked;
            reg         source_level;
            wire        qualified;
            wire        active;
            wire        next_state;
            wire        capture_on;

            assign cfg = cfg_flat[ch*32 +: 32];

            // Event input arrives from asynchronous routing: two flops first.
            always @(posedge clk_in or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    evt_meta <= 1'b0;
                    evt_sync <= 1'b0;
                end else begin
                    evt_meta <= fault_event_input_in[ch];
                    evt_sync <= evt_meta;
                end
            end

            // Steady-sample filter on the synchronised event.
            fault_input_filter filter (
                .clk_in     (clk_in),
                .reset_n_in (rst_sync_n),
                .sample_in  (evt_sync),
                .length_in  (cfg[`F_FILTER_HI:`F_FILTER_LO]),
                .level_out  (evt_filtered)
            );

            // Blanking window opened by selected compare output edges.
            fault_blank_timer blank (
                .clk_in      (clk_in),
                .reset_n_in  (rst_sync_n),
                .level_in    (compare_output_level_in[ch]),
                .mode_in     (cfg[`F_BLANK_HI:`F_BLANK_LO]),
                .duration_in (cfg[`F_BLANKDUR_HI:`F_BLANKDUR_LO]),
                .tick_in     (prescale_tick_in),
                .blanked_out (blanked)
            );

            // Source selection, including the other fault's last-period state.
            always @* begin
                case (cfg[`F_SRC_HI:`F_SRC_LO])
                    `SRC_EVENT:       source_level = evt_filtered;
                    `SRC_INVERT:      source_level = ~evt_filtered;
                    `SRC_OTHER_FAULT: source_level = state_at_period_end[1-ch];
                    default:          source_level = 1'b0;
                endcase
            end

            // The input counts only while the compare output is high if asked.
            assign qualified = ~cfg[`F_QUALIFY] | compare_output_level_in[ch];

            // Blanking hides the input for the whole window.
            assign active = source_level & qualified & ~blanked;

            // Keep holds the state until the counter cycle ends.
            assign next_state = active |
                                (cfg[`F_KEEP] & state[ch] & ~cycle_end_in);

            // Capture is requested for every action but none and the reserved code.
            assign capture_on = (cfg[`F_CAPT_HI:`F_CAPT_LO] != `CAPT_NONE) &&
                                (cfg[`F_CAPT_HI:`F_CAPT_LO] != `CAPT_RESERVED);

            assign fault_onset[ch] = next_state & ~state[ch];

            // Fault state and the snapshot taken at each period end.
            always @(posedge clk_in or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    state[ch]               <= 1'b0;
                    state_at_period_end[ch] <= 1'b0;
                end else begin
                    state[ch] <= next_state;
                    if (cycle_end_in) begin
                        state_at_period_end[ch] <= state[ch];
                    end
                end
            end

            // Registered results handed to the counter core.
            always @(posedge clk_in or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    fault_state_out[ch]                <= 1'b0;
                    capture_request_out[ch]            <= 1'b0;
                    capture_action_out[ch*3 +: 3]      <= `CAPT_NONE;
                    capture_channel_select_out[ch*2 +: 2] <= 2'h0;
                    halt_hardware_out[ch]              <= 1'b0;
                    halt_software_out[ch]              <= 1'b0;
                    non_recoverable_out[ch]            <= 1'b0;
                    restart_out[ch]                    <= 1'b0;
                end else begin
                    fault_state_out[ch]     <= next_state;
                    capture_request_out[ch] <= fault_onset[ch] & capture_on;
                    capture_action_out[ch*3 +: 3] <= cfg[`F_CAPT_HI:`F_CAPT_LO];
                    capture_channel_select_out[ch*2 +: 2] <=
                        cfg[`F_CAPTURE_CHANNEL_SELECT_HI:`F_CAPTURE_CHANNEL_SELECT_LO];
                    halt_hardware_out[ch] <= next_state &
                        (cfg[`F_HALT_HI:`F_HALT_LO] == `HALT_HARDWARE);
                    halt_software_out[ch] <= next_state &
                        (cfg[`F_HALT_HI:`F_HALT_LO] == `HALT_SOFTWARE);
                    non_recoverable_out[ch] <= next_state &
                        (cfg[`F_HALT_HI:`F_HALT_LO] == `HALT_NON_RECOVER);
                    restart_out[ch] <= fault_onset[ch] & cfg[`F_RESTART];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== pkg/fault_map.vh ====
// Register map, field positions and encodings of the recoverable fault block.
`ifndef FAULT_MAP_VH
`define FAULT_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_W              8
`define OFF_FAULT_A_CONFIG  8'h0c
`define OFF_FAULT_B_CONFIG  8'h10
`define OFF_IRQ_STATUS      8'h20
`define OFF_IRQ_CLEAR       8'h24
`define OFF_IRQ_ENABLE      8'h28

// ----------------------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------------------
`define CFG_RESET           32'h00000000
`define CFG_WRITE_MASK      32'h0fff7ffb
`define F_FILTER_HI         27
`define F_FILTER_LO         24
`define F_BLANKDUR_HI       23
`define F_BLANKDUR_LO       16
`define F_CAPT_HI           14
`define F_CAPT_LO           12
`define F_CAPTURE_CHANNEL_SELECT_HI          11
`define F_CAPTURE_CHANNEL_SELECT_LO          10
`define F_HALT_HI           9
`define F_HALT_LO           8
`define F_RESTART           7
`define F_BLANK_HI          6
`define F_BLANK_LO          5
`define F_QUALIFY           4
`define F_KEEP              3
`define F_SRC_HI            1
`define F_SRC_LO            0

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define SRC_DISABLE         2'h0
`define SRC_EVENT           2'h1
`define SRC_INVERT          2'h2
`define SRC_OTHER_FAULT     2'h3
`define BLANK_NONE          2'h0
`define BLANK_RISE          2'h1
`define BLANK_FALL          2'h2
`define BLANK_BOTH          2'h3
`define HALT_DISABLE        2'h0
`define HALT_HARDWARE       2'h1
`define HALT_SOFTWARE       2'h2
`define HALT_NON_RECOVER    2'h3
`define CAPT_NONE           3'h0
`define CAPT_RESERVED       3'h7
`define IRQ_W               2
`define IRQ_ZERO            2'h0
`define WORD_ZERO           32'h00000000

`endif

// ==== design/fault_input_filter.v ====
// Sample-count filter that accepts a new input level only once it has held steady.
`timescale 1ns/1ns
`default_nettype none
`include "fault_map.vh"

module fault_input_filter (
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire       sample_in,
    input  wire [3:0] length_in,
    output reg        level_out
);

    reg  [3:0] run;
    wire [3:0] next_run;

    // Count of consecutive samples that differ from the accepted level.
    assign next_run = run + 4'h1;

    // ------------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------------
    // A zero length passes samples straight through; otherwise the level flips
    // only after length_in consecutive disagreeing samples.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run       <= 4'h0;
            level_out <= 1'b0;
        end else if (length_in == 4'h0) begin
            run       <= 4'h0;
            level_out <= sample_in;
        end else if (sample_in != level_out) begin
            if (next_run >= length_in) begin
                run       <= 4'h0;
                level_out <= sample_in;
            end else begin
                run <= next_run;
            end
        end else begin
            run <= 4'h0;
        end
    end

endmodule
`default_nettype wire

// ==== design/fault_blank_timer.v ====
// Blanking window timer started by selected edges of the compare output.
`timescale 1ns/1ns
`default_nettype none
`include "fault_map.vh"

module fault_blank_timer (
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire       level_in,
    input  wire [1:0] mode_in,
    input  wire [7:0] duration_in,
    input  wire       tick_in,
    output wire       blanked_out
);

    reg       level_d;
    reg [7:0] remain;
    reg       start;

    // ------------------------------------------------------------------------
    // Edge selection
    // ------------------------------------------------------------------------
    // Picks which waveform edges open a blanking window.
    always @* begin
        case (mode_in)
            `BLANK_RISE: start = level_in & ~level_d;
            `BLANK_FALL: start = ~level_in & level_d;
            `BLANK_BOTH: start = level_in ^ level_d;
            default:     start = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Window counter
    // ------------------------------------------------------------------------
    // Loads the duration on an edge and counts down on prescaled ticks.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            level_d <= 1'b0;
            remain  <= 8'h00;
        end else begin
            level_d <= level_in;
            if (start) begin
                remain <= duration_in;
            end else if (tick_in && remain != 8'h00) begin
                remain <= remain - 8'h01;
            end
        end
    end

    // The input is held off while any of the window remains.
    assign blanked_out = (remain != 8'h00);

endmodule
`default_nettype wire

// ==== tb/fault_event_source.sv ====
// Model of the event routing that feeds the two fault event inputs.
`timescale 1ns/1ns
`default_nettype none

module fault_event_source (
    input  wire logic [1:0] level_in,
    output var  logic [1:0] event_out
);
    // Events arrive off the clock grid, as an asynchronous route would deliver them.
    initial begin
        event_out = 2'h0;
        forever @(level_in) event_out <= #3 level_in;
    end
endmodule

`default_nettype wire

// ==== tb/recoverable_fault_config_sva.sv ====
// Checker of the recoverable fault block, watching its ports only.
`timescale 1ns/1ns
`default_nettype none
`include "fault_map.vh"

module fault_config_checker (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic        write_in,
    input wire logic        read_in,
    input wire logic [31:0] rdata_out,
    input wire logic        timer_enabled_in,
    input wire logic        write_protect_in,
    input wire logic [1:0]  fault_state_out,
    input wire logic [1:0]  capture_request_out,
    input wire logic [5:0]  capture_action_out,
    input wire logic [1:0]  halt_hardware_out,
    input wire logic [1:0]  halt_software_out,
    input wire logic [1:0]  non_recoverable_out,
    input wire logic [1:0]  restart_out,
    input wire logic        irq_out
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Read data stand only in the cycle after a read strobe.
    a_rdata_idle: assert property (!$past(read_in) |-> rdata_out == `WORD_ZERO)
        else $error("read data not zero outside a read");
    // Reserved configuration bits always read as zero.
    a_reserved_rd: assert property ($past(read_in) && ($past(addr_in) == `OFF_FAULT_A_CONFIG
        || $past(addr_in) == `OFF_FAULT_B_CONFIG) |-> (rdata_out & ~`CFG_WRITE_MASK) == 32'h0)
        else $error("reserved configuration bit read as one");
    // While the timer runs or is protected, a write with no write before it leaves the capture action steady into the next cycle.
    a_locked_write: assert property (write_in && (timer_enabled_in || write_protect_in)
        && !$past(write_in) |=> $stable(capture_action_out))
        else $error("locked write changed the capture action");
    // Halt outputs only stand while the fault state does.
    a_halt_state: assert property (((halt_hardware_out | halt_software_out
        | non_recoverable_out) & ~fault_state_out) == 2'h0)
        else $error("halt output without fault state");
    // At most one halt kind is active per channel.
    a_halt_excl: assert property (((halt_hardware_out & halt_software_out)
        | (halt_hardware_out & non_recoverable_out)
        | (halt_software_out & non_recoverable_out)) == 2'h0)
        else $error("two halt kinds at once");
    // Capture and restart pulses come only at fault onset.
    a_onset_pulse: assert property (((capture_request_out | restart_out)
        & ~(fault_state_out & ~$past(fault_state_out))) == 2'h0)
        else $error("capture or restart pulse away from onset");
    // A fault A capture request needs an action code from one to six.
    a_capt_action: assert property (capture_request_out[0] |->
        capture_action_out[2:0] != `CAPT_NONE && capture_action_out[2:0] != `CAPT_RESERVED)
        else $error("capture request with no valid action");
    // The interrupt rises with a fault onset or after any register write in the cycle before.
    a_irq_cause: assert property ($rose(irq_out) |-> $rose(fault_state_out[0])
        || $rose(fault_state_out[1]) || $past(write_in))
        else $error("interrupt rose without cause");

    // Main scenarios seen.
    c_capture: cover property (capture_request_out[0]);
    c_restart: cover property (restart_out[0]);
    c_nonrec: cover property (non_recoverable_out[0]);
    c_irq: cover property ($rose(irq_out));
endmodule

bind recoverable_fault_config fault_config_checker chk_i (
    .clk_in, .reset_n_in, .addr_in, .write_in, .read_in, .rdata_out, .timer_enabled_in,
    .write_protect_in, .fault_state_out, .capture_request_out, .capture_action_out,
    .halt_hardware_out, .halt_software_out, .non_recoverable_out, .restart_out, .irq_out
);

`default_nettype wire

// ==== tb/recoverable_fault_config_tb.sv ====
// Self-checking testbench of the recoverable fault block.
`timescale 1ns/1ns
`default_nettype none
`include "fault_map.vh"

module recoverable_fault_config_tb;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic        write_in = 1'b0;
    logic        read_in = 1'b0;
    logic        timer_enabled_in = 1'b0;
    logic        write_protect_in = 1'b0;
    logic        prescale_tick_in = 1'b0;
    logic        cycle_end_in = 1'b0;
    logic [1:0]  cmp = 2'h0;
    logic [1:0]  ev = 2'h0;
    logic [1:0]  div = 2'h0;
    logic [1:0]  event_w;
    logic [31:0] rdata_out;
    logic [1:0]  fault_state_out;
    logic [1:0]  capture_request_out;
    logic [5:0]  capture_action_out;
    logic [3:0]  capture_channel_select_out;
    logic [1:0]  halt_hardware_out;
    logic [1:0]  halt_software_out;
    logic [1:0]  non_recoverable_out;
    logic [1:0]  restart_out;
    logic        irq_out;
    int          n_fail = 0;
    int          n_compared = 0;

    recoverable_fault_config uut (
        .clk_in, .reset_n_in, .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
        .timer_enabled_in, .write_protect_in, .prescale_tick_in, .cycle_end_in,
        .compare_output_level_in(cmp), .fault_event_input_in(event_w), .fault_state_out,
        .capture_request_out, .capture_action_out, .capture_channel_select_out,
        .halt_hardware_out, .halt_software_out, .non_recoverable_out, .restart_out, .irq_out
    );
    fault_event_source src_i (.level_in(ev), .event_out(event_w));

    // 10 ns clock and a prescaler tick every fourth cycle.
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        div <= div + 2'h1;
        prescale_tick_in <= (div == 2'h3);
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clk_in);
        write_in <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clk_in);
        read_in <= 1'b0;
        @(posedge clk_in) chk(rdata_out, e);
    endtask
    task automatic set_ev(input logic [1:0] v);
        @(posedge clk_in);
        ev <= v;
    endtask
    task automatic cyc_end;
        @(posedge clk_in);
        cycle_end_in <= 1'b1;
        @(posedge clk_in);
        cycle_end_in <= 1'b0;
    endtask
    // Waits out the path latency, then up to 40 cycles for the fault state to reach v.
    task automatic wfs(input int b, input logic v);
        int n;
        n = 0;
        repeat (6) @(posedge clk_in);
        #1;
        while (fault_state_out[b] !== v && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk(fault_state_out[b], v);
    endtask
    task automatic irq_is(input logic v);
        @(posedge clk_in);
        #1 chk(irq_out, v);
    endtask
    // Moves the compare level, then looks inside and after the blanking window.
    task automatic edge_chk(input logic [1:0] c, input logic bl);
        @(posedge clk_in);
        cmp <= c;
        repeat (5) @(posedge clk_in);
        #1 chk(fault_state_out[0], !bl);
        repeat (6) @(posedge clk_in);
        #1 chk(fault_state_out[0], !bl);
        wfs(0, 1'b1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdc(`OFF_FAULT_A_CONFIG, `CFG_RESET);
        rdc(`OFF_FAULT_B_CONFIG, `CFG_RESET);
        rdc(`OFF_IRQ_ENABLE, 32'h0);
        wr(`OFF_FAULT_A_CONFIG, 32'hffffffff);
        wr(`OFF_FAULT_B_CONFIG, 32'hffffffff);
        rdc(`OFF_FAULT_A_CONFIG, 32'h0fff7ffb);
        rdc(`OFF_FAULT_B_CONFIG, 32'h0fff7ffb);
        rdc(8'h04, 32'h0);
        rdc(`OFF_IRQ_CLEAR, 32'h0);
        timer_enabled_in <= 1'b1;
        wr(`OFF_FAULT_A_CONFIG, 32'h0);
        rdc(`OFF_FAULT_A_CONFIG, 32'h0fff7ffb);
        timer_enabled_in <= 1'b0;
        write_protect_in <= 1'b1;
        wr(`OFF_FAULT_B_CONFIG, 32'h0);
        rdc(`OFF_FAULT_B_CONFIG, 32'h0fff7ffb);
        write_protect_in <= 1'b0;
        wr(`OFF_FAULT_A_CONFIG, 32'h0);
        wr(`OFF_FAULT_B_CONFIG, 32'h0);
        rdc(`OFF_FAULT_A_CONFIG, 32'h0);
    endtask
    task automatic t_src;
        for (int s = 0; s < 3; s++) begin
            wr(`OFF_FAULT_A_CONFIG, s);
            set_ev(2'h1);
            wfs(0, s == 1);
            set_ev(2'h0);
            wfs(0, s == 2);
        end
        wr(`OFF_FAULT_B_CONFIG, 32'h1);
        wr(`OFF_FAULT_A_CONFIG, 32'h3);
        set_ev(2'h2);
        wfs(1, 1'b1);
        wfs(0, 1'b0);
        cyc_end;
        wfs(0, 1'b1);
        set_ev(2'h0);
        wfs(1, 1'b0);
        wfs(0, 1'b1);
        cyc_end;
        wfs(0, 1'b0);
        wr(`OFF_FAULT_B_CONFIG, 32'h0);
    endtask
    task automatic t_actions;
        logic [2:0] c;
        int n;
        for (int i = 0; i < 8; i++) begin
            c = i;
            wr(`OFF_FAULT_A_CONFIG, {17'h0, c, c[1:0], c[1:0], c[0], 7'h01});
            set_ev(2'h1);
            n = 0;
            while (fault_state_out[0] !== 1'b1 && n < 40) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            chk(fault_state_out[0], 1'b1);
            chk(capture_request_out[0], c != 3'h0 && c != 3'h7);
            chk(capture_action_out[2:0], c);
            chk(capture_channel_select_out[1:0], c[1:0]);
            chk(restart_out[0], c[0]);
            chk({non_recoverable_out[0], halt_software_out[0], halt_hardware_out[0]},
                {c[1:0] == 2'h3, c[1:0] == 2'h2, c[1:0] == 2'h1});
            set_ev(2'h0);
            wfs(0, 1'b0);
        end
    endtask
    task automatic t_output_level_qualify_keep;
        wr(`OFF_FAULT_A_CONFIG, 32'h11);
        set_ev(2'h1);
        wfs(0, 1'b0);
        @(posedge clk_in);
        cmp <= 2'h1;
        wfs(0, 1'b1);
        set_ev(2'h0);
        wfs(0, 1'b0);
        wr(`OFF_FAULT_A_CONFIG, 32'h9);
        set_ev(2'h1);
        wfs(0, 1'b1);
        set_ev(2'h0);
        wfs(0, 1'b1);
        cyc_end;
        wfs(0, 1'b0);
        @(posedge clk_in);
        cmp <= 2'h0;
    endtask
    task automatic t_blank;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i;
            wr(`OFF_FAULT_A_CONFIG, {25'h000800, m, 5'h01});
            set_ev(2'h1);
            wfs(0, 1'b1);
            edge_chk(2'h1, m[0]);
            edge_chk(2'h0, m[1]);
            set_ev(2'h0);
            wfs(0, 1'b0);
        end
    endtask
    task automatic t_filter;
        wr(`OFF_FAULT_A_CONFIG, 32'h05000001);
        set_ev(2'h1);
        repeat (2) @(posedge clk_in);
        set_ev(2'h0);
        repeat (12) @(posedge clk_in);
        #1 chk(fault_state_out[0], 1'b0);
        set_ev(2'h1);
        wfs(0, 1'b1);
        set_ev(2'h0);
        wfs(0, 1'b0);
    endtask
    task automatic t_irq;
        wr(`OFF_FAULT_A_CONFIG, 32'h1);
        wr(`OFF_IRQ_CLEAR, 32'h3);
        rdc(`OFF_IRQ_STATUS, 32'h0);
        wr(`OFF_IRQ_ENABLE, 32'h1);
        irq_is(1'b0);
        set_ev(2'h1);
        wfs(0, 1'b1);
        irq_is(1'b1);
        rdc(`OFF_IRQ_STATUS, 32'h1);
        wr(`OFF_IRQ_ENABLE, 32'h0);
        irq_is(1'b0);
        wr(`OFF_IRQ_ENABLE, 32'h1);
        irq_is(1'b1);
        wr(`OFF_IRQ_CLEAR, 32'h1);
        irq_is(1'b0);
        rdc(`OFF_IRQ_STATUS, 32'h0);
        set_ev(2'h0);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic summarize;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reset for 12 cycles, then every scenario in turn.
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_regs;
        t_src;
        t_actions;
        t_output_level_qualify_keep;
        t_blank;
        t_filter;
        t_irq;
        summarize;
    end

    // Watchdog far past the run length.
    initial begin
        #300000;
        n_fail++;
        summarize;
    end
endmodule

`default_nettype wire
